// >>> verilog/dsmr_pkg.sv
// Constants, register map and code enumerations for the drive status and monitor register bank.
package dsmr_pkg;

   // ***************************************************************
   // Register map.
   // ***************************************************************
   localparam logic [15:0] REG_CONTROL_WORD           = 16'h4000;
   localparam logic [15:0] REG_FREQ_SETPOINT          = 16'h4001;
   localparam logic [15:0] REG_DRIVE_STATE_WORD       = 16'h5000;
   localparam logic [15:0] REG_OUTPUT_FREQUENCY       = 16'h5001;
   localparam logic [15:0] REG_REFERENCE_FREQUENCY    = 16'h5002;
   localparam logic [15:0] REG_OUTPUT_CURRENT         = 16'h5003;
   localparam logic [15:0] REG_DC_LINK_VOLTAGE        = 16'h5004;
   localparam logic [15:0] REG_HEATSINK_TEMP          = 16'h5005;
   localparam logic [15:0] REG_OUTPUT_VOLTAGE         = 16'h5006;
   localparam logic [15:0] REG_OUTPUT_POWER           = 16'h5007;
   localparam logic [15:0] REG_TORQUE_CURRENT         = 16'h5008;
   localparam logic [15:0] REG_EXCITING_CURRENT       = 16'h5009;
   localparam logic [15:0] REG_OUTPUT_SPEED           = 16'h500a;
   localparam logic [15:0] REG_REFERENCE_SPEED        = 16'h500b;
   localparam logic [15:0] REG_USER_REFERENCE_VALUE   = 16'h500c;
   localparam logic [15:0] REG_USER_OUTPUT_VALUE      = 16'h500d;
   localparam logic [15:0] REG_REFERENCE_TORQUE       = 16'h500e;
   localparam logic [15:0] REG_DIGITAL_INPUT_STATES   = 16'h500f;
   localparam logic [15:0] REG_ENCODER_SPEED_FEEDBACK = 16'h5010;
   localparam logic [15:0] REG_TORQUE_LIMIT_VALUE     = 16'h5011;
   localparam logic [15:0] REG_SPEED_LIMIT_VALUE      = 16'h5012;
   localparam logic [15:0] REG_MULTI_MONITOR_DISPLAY  = 16'h5013;
   localparam logic [15:0] MULTI_MONITOR_READ_VALUE   = 16'h0000;

   // ***************************************************************
   // Field positions and reset values.
   // ***************************************************************
   localparam int SW_FAULT_CODE_LSB  = 11;
   localparam int SW_FAULT_CODE_MSB  = 15;
   localparam int SW_RESERVED_LSB    = 8;
   localparam int SW_RESERVED_MSB    = 10;
   localparam int SW_FAULT           = 7;
   localparam int SW_STALL_OC        = 6;
   localparam int SW_STALL_OV        = 5;
   localparam int SW_DECEL           = 4;
   localparam int SW_ACCEL           = 3;
   localparam int SW_JOG             = 2;
   localparam int SW_RUN             = 1;
   localparam int SW_REVERSE         = 0;
   localparam int CW_GENERAL         = 0;
   localparam int CW_JOG             = 1;
   localparam int CW_REVERSE         = 2;
   localparam int CW_STOP_PARAM      = 3;
   localparam int CW_EMERGENCY_STOP  = 4;
   localparam int CW_FAULT_RESET     = 5;
   localparam logic [15:0] CONTROL_WORD_RESET  = 16'h0000;
   localparam logic [15:0] FREQ_SETPOINT_RESET = 16'h0000;
   localparam int FAULT_SOURCES      = 24;

   // ***************************************************************
   // Frame layout, function codes and exception codes.
   // ***************************************************************
   localparam int RX_DEPTH           = 16;
   localparam logic [4:0] RX_MIN_LEN = 5'h06;
   localparam logic [4:0] RX_MULTI_FIXED = 5'h07;
   localparam logic [5:0] RSP_LEN_EXC    = 6'h03;
   localparam logic [5:0] RSP_LEN_WRITE  = 6'h06;
   localparam logic [5:0] RSP_LEN_RD_HDR = 6'h03;
   localparam logic [15:0] RD_MAX_QTY    = 16'h0014;
   localparam logic [15:0] WR_MAX_QTY    = 16'h0002;
   localparam logic [7:0] BROADCAST_ADDR = 8'h00;
   localparam logic [7:0] FN_READ_HOLDING = 8'h03;
   localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
   localparam logic [7:0] FN_WRITE_MULTI  = 8'h10;
   localparam logic [7:0] FN_EXC_FLAG     = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FN    = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_SEND = 2'b10
   } dsmr_state_t;

   // Fault codes carried in the top five bits of the state word.
   typedef enum logic [4:0] {
      FAULT_NONE              = 5'h00, OVERCURRENT_CONST_SPEED = 5'h01, OVERCURRENT_ACCEL     = 5'h02,
      OVERCURRENT_DECEL       = 5'h03, OVERVOLTAGE_CONST_SPEED = 5'h04, OVERVOLTAGE_ACCEL     = 5'h05,
      OVERVOLTAGE_DECEL       = 5'h06, DRIVE_OVERLOAD          = 5'h07, MOTOR_OVERLOAD        = 5'h08,
      MEMORY_ACCESS_FAULT     = 5'h09, KEYPAD_FAULT            = 5'h0a, EXTERNAL_FAULT        = 5'h0b,
      COMM_FAULT              = 5'h0c, CIRCUIT_DISCONNECT      = 5'h0d, ENCODER_FAULT         = 5'h0e,
      MOTOR_OVERHEAT          = 5'h0f, INTERFERENCE_FAULT      = 5'h10, SHORT_CIRCUIT         = 5'h11,
      FAULT_RESERVED          = 5'h12, INPUT_PHASE_LOSS        = 5'h13, OUTPUT_PHASE_LOSS     = 5'h14,
      DRIVE_OVERHEAT          = 5'h15, PARAM_SETTING_FAULT     = 5'h16, AUTOTUNE_FAULT        = 5'h17,
      OVERLOAD_PREWARNING     = 5'h18
   } dsmr_fault_t;

endpackage

// >>> verilog/dsmr_drive_status_monitor_regs.sv
// Drive state word, monitor block and host control registers behind a request/response frame port.
`timescale 1ns/100ps
// What this block does
// RL1: State word at 0x5000, read-only, writes rejected.
// RL2: Fault code bits 15-11, bits 10-8 reserved.
// RL3: Flags: fault, stalls, decel, accel, jog, run, reverse.
// RL4: Codes 0-8: none, overcurrents, overvoltages, overloads.
// RL5: Codes 9-17: memory through short circuit faults.
// RL6: Code 18 reserved; 19-24 phase through prewarning.
// RL7: Monitor words read-only at 0x5001-0x5013.
// RL8: 0x5001-0x5009 frequency, current, voltage, temperature, power quantities.
// RL9: 0x500A-0x5012 speeds, user values, torque, digital inputs, limits.
// RL10: Address 0x5013 always reads zero.
// RL11: Master starts drive via multi-write at 0x4000.
// RL12: Multi-write reply: address, function, start, quantity.
// RL13: Frequency setpoint in hundredths of a hertz.
// RL14: Single write echoed; 0x0008 requests parameterised stop.
// RL15: Host writes accepted only under host sources.
// RL16: Read reply: byte count, words high byte first.
// RL17: Control word 0x4000 write-only, bits 0-5.
// RL18: Setpoint 0x4001 write-only, needs communication source.
module dsmr_drive_status_monitor_regs #(
   parameter logic [7:0] SLAVE_ADDR = 8'h01
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        reqValid,
   input  wire logic [7:0]  reqByte,
   input  wire logic        reqLast,
   output logic             reqReady,
   output logic             rspValid,
   output logic [7:0]       rspByte,
   output logic             rspLast,
   input  wire logic        rspReady,
   input  wire logic        cmdSourceHost,
   input  wire logic        freqSourceHost,
   input  wire logic [23:0] faultVector,
   input  wire logic        stallOvercurrent,
   input  wire logic        stallOvervoltage,
   input  wire logic        decelerating,
   input  wire logic        accelerating,
   input  wire logic        jogging,
   input  wire logic        running,
   input  wire logic        reverse,
   input  wire logic [15:0] outputFrequency,
   input  wire logic [15:0] referenceFrequency,
   input  wire logic [15:0] outputCurrent,
   input  wire logic [15:0] dcLinkVoltage,
   input  wire logic [15:0] heatsinkTemp,
   input  wire logic [15:0] outputVoltage,
   input  wire logic [15:0] outputPower,
   input  wire logic [15:0] torqueCurrent,
   input  wire logic [15:0] excitingCurrent,
   input  wire logic [15:0] outputSpeed,
   input  wire logic [15:0] referenceSpeed,
   input  wire logic [15:0] userReferenceValue,
   input  wire logic [15:0] userOutputValue,
   input  wire logic [15:0] referenceTorque,
   input  wire logic [15:0] digitalInputStates,
   input  wire logic [15:0] encoderSpeedFeedback,
   input  wire logic [15:0] torqueLimitValue,
   input  wire logic [15:0] speedLimitValue,
   output logic             ctrlGeneral,
   output logic             ctrlJog,
   output logic             ctrlReverse,
   output logic             ctrlStopParam,
   output logic             ctrlEmergencyStop,
   output logic             ctrlFaultReset,
   output logic             ctrlStrobe,
   output logic [15:0]      freqSetpoint,
   output logic             freqStrobe
);

   // ***************************************************************
   // Declarations and helpers.
   // ***************************************************************
   dsmr_pkg::dsmr_state_t state;
   logic [7:0]  rxBuf [0:dsmr_pkg::RX_DEPTH-1];
   logic [4:0]  rxCount;
   logic        rxOverflow;
   logic [15:0] controlWord;
   logic [15:0] stateWord;
   logic [15:0] monBank [0:19];
   logic [5:0]  txIdx;
   logic [5:0]  rspLen;
   logic        rspIsExc;
   logic        rspIsRead;
   logic [7:0]  excCode;
   logic [15:0] startAddr;
   logic [15:0] qtyField;
   logic [16:0] lastAddr;
   logic [7:0]  fnCode;
   logic        next_reply;
   logic        next_isExc;
   logic        next_isRead;
   logic [7:0]  next_excCode;
   logic [5:0]  next_len;
   logic        next_wrCtrl;
   logic        next_wrFreq;
   logic [15:0] next_ctrlVal;
   logic [15:0] next_freqVal;
   logic [5:0]  nextIdx;
   logic        hostOk;

   // Lowest active source wins; the reserved slot never reports.
   function automatic logic [4:0] faultEncode(input logic [23:0] v);
      logic [4:0] code;
      code = dsmr_pkg::FAULT_NONE;
      for (int i = dsmr_pkg::FAULT_SOURCES - 1; i >= 0; i--) begin
         if (v[i] && (5'(i + 1) != dsmr_pkg::FAULT_RESERVED)) begin // RL6
            code = 5'(i + 1); // RL4 RL5
         end
      end
      return code;
   endfunction

   // Maps a register address inside the read window onto the bank index.
   function automatic logic [4:0] regIndex(input logic [15:0] a);
      return a[4:0] - dsmr_pkg::REG_DRIVE_STATE_WORD[4:0];
   endfunction

   // ***************************************************************
   // Read-side register bank.
   // ***************************************************************
   // State word is assembled live, so a read always reflects the present cycle.
   always_comb begin
      stateWord = 16'h0000; // RL2
      stateWord[dsmr_pkg::SW_FAULT_CODE_MSB:dsmr_pkg::SW_FAULT_CODE_LSB] = faultEncode(faultVector); // RL2
      stateWord[dsmr_pkg::SW_FAULT]   = (faultEncode(faultVector) != dsmr_pkg::FAULT_NONE); // RL3
      stateWord[dsmr_pkg::SW_STALL_OC] = stallOvercurrent; // RL3
      stateWord[dsmr_pkg::SW_STALL_OV] = stallOvervoltage;
      stateWord[dsmr_pkg::SW_DECEL]    = decelerating;
      stateWord[dsmr_pkg::SW_ACCEL]    = accelerating;
      stateWord[dsmr_pkg::SW_JOG]      = jogging;
      stateWord[dsmr_pkg::SW_RUN]      = running;
      stateWord[dsmr_pkg::SW_REVERSE]  = reverse;
   end

   // Monitor words in address order; the last slot is a constant.
   assign monBank = '{stateWord, outputFrequency, referenceFrequency, outputCurrent, dcLinkVoltage, // RL1 RL8
      heatsinkTemp, outputVoltage, outputPower, torqueCurrent, excitingCurrent, outputSpeed, referenceSpeed, // RL9
      userReferenceValue, userOutputValue, referenceTorque, digitalInputStates, encoderSpeedFeedback,
      torqueLimitValue, speedLimitValue, dsmr_pkg::MULTI_MONITOR_READ_VALUE}; // RL10

   // ***************************************************************
   // Request reception.
   // ***************************************************************
   assign reqReady = (state == dsmr_pkg::ST_IDLE);

   // Bytes past the buffer depth mark the frame as oversized; it is dropped whole.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rxCount    <= 5'h00;
         rxOverflow <= 1'b0;
      end else if (ce) begin
         if (state == dsmr_pkg::ST_EXEC) begin
            rxCount    <= 5'h00;
            rxOverflow <= 1'b0;
         end else if (reqValid && reqReady) begin
            if (rxCount < 5'(dsmr_pkg::RX_DEPTH)) begin
               rxBuf[rxCount[3:0]] <= reqByte;
               rxCount             <= rxCount + 5'h01;
            end else begin
               rxOverflow <= 1'b1;
            end
         end
      end
   end

   // ***************************************************************
   // Frame decode, done in the single execute cycle.
   // ***************************************************************
   assign fnCode    = rxBuf[1];
   assign startAddr = {rxBuf[2], rxBuf[3]};
   assign qtyField  = {rxBuf[4], rxBuf[5]};
   assign lastAddr  = {1'b0, startAddr} + {1'b0, qtyField} - 17'h00001;
   assign hostOk    = cmdSourceHost && freqSourceHost; // RL15 RL18

   always_comb begin
      next_reply   = (rxBuf[0] == SLAVE_ADDR) && !rxOverflow && (rxCount >= dsmr_pkg::RX_MIN_LEN);
      next_isExc   = 1'b0;
      next_isRead  = 1'b0;
      next_excCode = dsmr_pkg::EXC_ILLEGAL_FN;
      next_len     = dsmr_pkg::RSP_LEN_WRITE;
      next_wrCtrl  = 1'b0;
      next_wrFreq  = 1'b0;
      next_ctrlVal = {rxBuf[4], rxBuf[5]};
      next_freqVal = {rxBuf[4], rxBuf[5]};
      case (fnCode)
         dsmr_pkg::FN_READ_HOLDING: begin
            next_isRead = 1'b1;
            next_len    = dsmr_pkg::RSP_LEN_RD_HDR + 6'(qtyField << 1); // RL16
            if (rxCount != dsmr_pkg::RX_MIN_LEN || qtyField == 16'h0000 || qtyField > dsmr_pkg::RD_MAX_QTY) begin
               next_isExc   = 1'b1;
               next_excCode = dsmr_pkg::EXC_ILLEGAL_VALUE;
            end else if (startAddr < dsmr_pkg::REG_DRIVE_STATE_WORD ||
                         lastAddr > {1'b0, dsmr_pkg::REG_MULTI_MONITOR_DISPLAY}) begin // RL7
               next_isExc   = 1'b1;
               next_excCode = dsmr_pkg::EXC_ILLEGAL_ADDR;
            end
         end
         dsmr_pkg::FN_WRITE_SINGLE: begin
            if (rxCount != dsmr_pkg::RX_MIN_LEN) begin
               next_isExc   = 1'b1;
               next_excCode = dsmr_pkg::EXC_ILLEGAL_VALUE;
            end else if (startAddr == dsmr_pkg::REG_CONTROL_WORD) begin
               next_wrCtrl = hostOk; // RL14 RL17
            end else if (startAddr == dsmr_pkg::REG_FREQ_SETPOINT) begin
               next_wrFreq = hostOk; // RL13 RL18
            end else begin
               next_isExc   = 1'b1; // RL1
               next_excCode = dsmr_pkg::EXC_ILLEGAL_ADDR;
            end
         end
         dsmr_pkg::FN_WRITE_MULTI: begin
            next_ctrlVal = {rxBuf[7], rxBuf[8]};
            next_freqVal = (startAddr == dsmr_pkg::REG_CONTROL_WORD) ? {rxBuf[9], rxBuf[10]} : {rxBuf[7], rxBuf[8]};
            if (qtyField == 16'h0000 || qtyField > dsmr_pkg::WR_MAX_QTY ||
                rxBuf[6] != 8'(qtyField << 1) ||
                rxCount != dsmr_pkg::RX_MULTI_FIXED + 5'(qtyField << 1)) begin
               next_isExc   = 1'b1;
               next_excCode = dsmr_pkg::EXC_ILLEGAL_VALUE;
            end else if (startAddr < dsmr_pkg::REG_CONTROL_WORD ||
                         lastAddr > {1'b0, dsmr_pkg::REG_FREQ_SETPOINT}) begin
               next_isExc   = 1'b1; // RL1
               next_excCode = dsmr_pkg::EXC_ILLEGAL_ADDR;
            end else begin
               next_wrCtrl = hostOk && (startAddr == dsmr_pkg::REG_CONTROL_WORD); // RL11 RL15
               next_wrFreq = hostOk && (lastAddr == {1'b0, dsmr_pkg::REG_FREQ_SETPOINT}); // RL13
            end
         end
         default: begin
            next_isExc = 1'b1;
         end
      endcase
      if (next_isExc) begin
         next_len = dsmr_pkg::RSP_LEN_EXC;
      end
   end

   // ***************************************************************
   // Sequencer.
   // ***************************************************************
   // Broadcast frames are executed but never answered.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= dsmr_pkg::ST_IDLE;
      end else if (ce) begin
         case (state)
            dsmr_pkg::ST_IDLE: begin
               if (reqValid && reqLast) begin
                  state <= dsmr_pkg::ST_EXEC;
               end
            end
            dsmr_pkg::ST_EXEC: begin
               state <= next_reply ? dsmr_pkg::ST_SEND : dsmr_pkg::ST_IDLE;
            end
            dsmr_pkg::ST_SEND: begin
               if (rspReady && rspLast) begin
                  state <= dsmr_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= dsmr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Host control registers.
   // ***************************************************************
   // Write-only from the link side; the drive sees them as levels plus a strobe.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         controlWord  <= dsmr_pkg::CONTROL_WORD_RESET;
         freqSetpoint <= dsmr_pkg::FREQ_SETPOINT_RESET;
         ctrlStrobe   <= 1'b0;
         freqStrobe   <= 1'b0;
      end else if (ce) begin
         ctrlStrobe <= 1'b0;
         freqStrobe <= 1'b0;
         if (state == dsmr_pkg::ST_EXEC && !rxOverflow && rxCount >= dsmr_pkg::RX_MIN_LEN && !next_isExc &&
             (rxBuf[0] == SLAVE_ADDR || rxBuf[0] == dsmr_pkg::BROADCAST_ADDR)) begin
            if (next_wrCtrl) begin
               controlWord <= next_ctrlVal; // RL17
               ctrlStrobe  <= 1'b1;
            end
            if (next_wrFreq) begin
               freqSetpoint <= next_freqVal; // RL13 RL18
               freqStrobe   <= 1'b1;
            end
         end
      end
   end

   assign ctrlGeneral       = controlWord[dsmr_pkg::CW_GENERAL]; // RL17
   assign ctrlJog           = controlWord[dsmr_pkg::CW_JOG];
   assign ctrlReverse       = controlWord[dsmr_pkg::CW_REVERSE];
   assign ctrlStopParam     = controlWord[dsmr_pkg::CW_STOP_PARAM]; // RL14
   assign ctrlEmergencyStop = controlWord[dsmr_pkg::CW_EMERGENCY_STOP];
   assign ctrlFaultReset    = controlWord[dsmr_pkg::CW_FAULT_RESET];

   // ***************************************************************
   // Response transmission.
   // ***************************************************************
   // Picks one reply byte; read data is sampled as the byte loads.
   function automatic logic [7:0] respByteAt(input logic [5:0] idx);
      logic [15:0] word;
      logic [4:0]  wIdx;
      wIdx = 5'((idx - 6'h03) >> 1);
      word = monBank[regIndex(startAddr + {11'h000, wIdx})];
      if (idx == 6'h00) begin
         return rxBuf[0];
      end else if (idx == 6'h01) begin
         return rspIsExc ? (fnCode | dsmr_pkg::FN_EXC_FLAG) : fnCode;
      end else if (rspIsExc) begin
         return excCode;
      end else if (rspIsRead) begin
         if (idx == 6'h02) begin
            return 8'(qtyField << 1); // RL16
         end
         return idx[0] ? word[15:8] : word[7:0]; // RL16
      end
      return rxBuf[idx[3:0]]; // RL12 RL14
   endfunction

   assign rspValid = (state == dsmr_pkg::ST_SEND);
   assign nextIdx  = txIdx + 6'h01;

   // Byte and last flag are registered; each accept loads the next.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txIdx     <= 6'h00;
         rspLen    <= dsmr_pkg::RSP_LEN_EXC;
         rspIsExc  <= 1'b0;
         rspIsRead <= 1'b0;
         excCode   <= dsmr_pkg::EXC_ILLEGAL_FN;
         rspByte   <= 8'h00;
         rspLast   <= 1'b0;
      end else if (ce) begin
         if (state == dsmr_pkg::ST_EXEC) begin
            txIdx     <= 6'h00;
            rspLen    <= next_len;
            rspIsExc  <= next_isExc;
            rspIsRead <= next_isRead;
            excCode   <= next_excCode;
            rspByte   <= rxBuf[0];
            rspLast   <= 1'b0;
         end else if (state == dsmr_pkg::ST_SEND && rspReady && !rspLast) begin
            txIdx   <= nextIdx;
            rspByte <= respByteAt(nextIdx);
            rspLast <= (nextIdx == rspLen - 6'h01);
         end
      end
   end

endmodule

// >>> test/dsmr_regs_props.sv
// Port checker for the drive status and monitor register bank.
`timescale 1ns/100ps
module dsmr_regs_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        reqValid,
   input wire logic        reqLast,
   input wire logic        reqReady,
   input wire logic        rspValid,
   input wire logic [7:0]  rspByte,
   input wire logic        rspLast,
   input wire logic        rspReady,
   input wire logic        cmdSourceHost,
   input wire logic        ctrlGeneral,
   input wire logic        ctrlStrobe,
   input wire logic [15:0] freqSetpoint,
   input wire logic        freqStrobe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Frame timing; a stalled reply byte must not slip while the master waits.
   a_exec_gap: assert property (reqValid && reqReady && reqLast |=> !reqReady && !rspValid)
      else $error("no gap after last request byte");
   a_busy_send: assert property (rspValid |-> !reqReady)
      else $error("request port open during reply");
   a_rsp_held: assert property (rspValid && !rspReady |=> rspValid && $stable(rspByte) && $stable(rspLast))
      else $error("reply byte moved while stalled");
   a_frame_done: assert property (rspValid && rspReady && rspLast |=> reqReady && !rspValid)
      else $error("port not idle after reply");
   // ctrlGeneral and freqSetpoint move only on a write that cmdSourceHost allows.
   a_write_gated: assert property (ctrlStrobe || freqStrobe |-> cmdSourceHost)
      else $error("write applied without host source");
   a_ctrl_strobe: assert property ($changed(ctrlGeneral) |-> ctrlStrobe)
      else $error("control bit moved without strobe");
   a_freq_strobe: assert property ($changed(freqSetpoint) |-> freqStrobe && !$past(reqReady))
      else $error("setpoint moved outside a write");
   a_reset_clear: assert property (disable iff (1'b0) rst |=> reqReady && !rspValid && freqSetpoint == 16'h0000)
      else $error("outputs not cleared by reset");
   c_frame: cover property (reqValid && reqReady && reqLast);
   c_stall: cover property (rspValid && !rspReady);
   c_freq: cover property (freqStrobe);
endmodule
bind dsmr_drive_status_monitor_regs dsmr_regs_props u_dsmr_regs_props (.clk_sys, .rst, .reqValid, .reqLast,
   .reqReady, .rspValid, .rspByte, .rspLast, .rspReady, .cmdSourceHost, .ctrlGeneral, .ctrlStrobe, .freqSetpoint,
   .freqStrobe);

// >>> test/dsmr_host_model.sv
// Bus master model that sends request frames and collects reply bytes.
`timescale 1ns/100ps
module dsmr_host_model (
   input  wire logic       clk_sys,
   output logic            reqValid,
   output logic [7:0]      reqByte,
   output logic            reqLast,
   input  wire logic       reqReady,
   input  wire logic       rspValid,
   input  wire logic [7:0] rspByte,
   input  wire logic       rspLast,
   output logic            rspReady
);
   logic [7:0] rsp[$];
   logic       slow = 1'b0;
   logic       hung = 1'b0;
   initial {reqValid, reqByte, reqLast, rspReady} = 11'h000;
   // Sends a frame and drains the reply; slow mode drops ready on every other cycle, so each byte after the first stalls once.
   task automatic xfer(input logic [7:0] req[$]);
      int n;
      rsp.delete();
      foreach (req[k]) begin
         n = 0;
         @(negedge clk_sys);
         while (!reqReady && n < 50) begin
            @(negedge clk_sys);
            n++;
         end
         hung |= (n == 50);
         reqValid = 1'b1;
         reqByte = req[k];
         reqLast = (k == req.size() - 1);
      end
      @(negedge clk_sys);
      reqValid = 1'b0;
      reqByte = ~reqByte; // A released bus never shows the stale byte.
      reqLast = 1'b0;
      for (n = 0; n < 100; n++) begin
         rspReady = !slow || n[0];
         if (rspValid && rspReady) rsp.push_back(rspByte);
         if (rspValid && rspReady && rspLast) break;
         @(negedge clk_sys);
      end
      hung |= (n == 100);
      @(negedge clk_sys);
      rspReady = 1'b0;
   endtask
endmodule

// >>> test/tb_drive_status_monitor_regs.sv
// Self-checking bench for the drive status and monitor register bank.
`timescale 1ns/100ps
module tb_drive_status_monitor_regs;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        cmdSourceHost = 1'b1, freqSourceHost = 1'b1;
   logic [23:0] faultVector = 24'h000000;
   logic [6:0]  flags = 7'h56;
   logic [15:0] m [0:17];
   logic [15:0] freqSetpoint;
   logic [7:0]  reqByte, rspByte;
   logic        reqValid, reqLast, reqReady, rspValid, rspLast, rspReady;
   wire  [5:0]  cw;
   logic [7:0]  q[$];
   int          error_cnt = 0;
   int          n_compared = 0;
   // Clock at 200 MHz and monitor values set at time zero.
   initial forever #2.5 clk_sys = ~clk_sys;
   initial for (int i = 0; i < 18; i++) m[i] = 16'h1000 + 16'(i);
   dsmr_drive_status_monitor_regs u_dsmr_drive_status_monitor_regs (.clk_sys, .rst, .ce(1'b1), .reqValid,
      .reqByte, .reqLast, .reqReady, .rspValid, .rspByte, .rspLast, .rspReady, .cmdSourceHost, .freqSourceHost,
      .faultVector, .stallOvercurrent(flags[6]), .stallOvervoltage(flags[5]), .decelerating(flags[4]),
      .accelerating(flags[3]), .jogging(flags[2]), .running(flags[1]), .reverse(flags[0]), .outputFrequency(m[0]),
      .referenceFrequency(m[1]), .outputCurrent(m[2]), .dcLinkVoltage(m[3]), .heatsinkTemp(m[4]),
      .outputVoltage(m[5]), .outputPower(m[6]), .torqueCurrent(m[7]), .excitingCurrent(m[8]), .outputSpeed(m[9]),
      .referenceSpeed(m[10]), .userReferenceValue(m[11]), .userOutputValue(m[12]), .referenceTorque(m[13]),
      .digitalInputStates(m[14]), .encoderSpeedFeedback(m[15]), .torqueLimitValue(m[16]), .speedLimitValue(m[17]),
      .ctrlGeneral(cw[0]), .ctrlJog(cw[1]), .ctrlReverse(cw[2]), .ctrlStopParam(cw[3]), .ctrlEmergencyStop(cw[4]),
      .ctrlFaultReset(cw[5]), .ctrlStrobe(), .freqSetpoint, .freqStrobe());
   dsmr_host_model u_dsmr_host_model (.clk_sys, .reqValid, .reqByte, .reqLast, .reqReady, .rspValid, .rspByte,
      .rspLast, .rspReady);
   // Compare helpers; a short reply fails its size check first.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkq(input logic [7:0] e[$]);
      chk(16'(u_dsmr_host_model.rsp.size()), 16'(e.size()));
      foreach (e[i]) chk(16'(u_dsmr_host_model.rsp[i]), 16'(e[i]));
   endtask
   function automatic logic [15:0] wd(input int k);
      return {u_dsmr_host_model.rsp[3 + 2 * k], u_dsmr_host_model.rsp[4 + 2 * k]};
   endfunction
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // A hung transfer counts as a mismatch and ends the run.
   task automatic run(input string name, input logic [7:0] f[$]);
      u_dsmr_host_model.xfer(f);
      $display("test %s done", name);
      if (u_dsmr_host_model.hung) begin
         error_cnt++;
         summarize();
      end
   endtask
   // Tests: monitor block, fault codes, read-only write, control writes, host gating.
   initial begin
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      run("monitor", '{8'h01, 8'h03, 8'h50, 8'h00, 8'h00, 8'h14});
      chk(16'(u_dsmr_host_model.rsp[2]), 16'h0028);
      chk(wd(0), 16'h0056);
      for (int i = 1; i < 19; i++) chk(wd(i), m[i - 1]);
      chk(wd(19), 16'h0000);
      for (int i = 0; i < 24; i++) begin
         faultVector = 24'h800000 | (24'h000001 << i);
         run("fault", '{8'h01, 8'h03, 8'h50, 8'h00, 8'h00, 8'h01});
         chk(wd(0), {(i == 17) ? 5'h18 : 5'(i + 1), 11'h0d6});
      end
      run("readonly", '{8'h01, 8'h06, 8'h50, 8'h00, 8'h12, 8'h34});
      chkq('{8'h01, 8'h86, 8'h02});
      u_dsmr_host_model.slow = 1'b1;
      run("start", '{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h13, 8'h88});
      chkq('{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h02});
      chk(freqSetpoint, 16'h1388);
      chk(16'(cw), 16'h0001);
      q = '{8'h01, 8'h06, 8'h40, 8'h00, 8'h00, 8'h36};
      run("ctrl", q);
      chk(16'(cw), 16'h0036);
      q[5] = 8'h08;
      run("stop", q);
      chkq(q);
      chk(16'(cw), 16'h0008);
      q = '{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h64};
      for (int s = 1; s < 3; s++) begin
         {cmdSourceHost, freqSourceHost} = 2'(s);
         run("nohost", q);
         chk(freqSetpoint, 16'h1388);
         chk(16'(cw), 16'h0008);
      end
      summarize();
   end
endmodule
